// file: txoob_pkg.sv
// Purpose: Constants and types for the lane transmit out-of-band block
// Assumes: 20 MHz clock, AHB-Lite register access, 32-bit data words
// Notes: Times are kept in ns; cycle counts are derived from them
//
// Notes on behaviour
// - Detect result is 3 when a far receiver exists, else 0.
// - Detect handshake runs on the lane's transmit user clock.
// - Com done is raised when the last burst of a sequence ends.
// - Init request starts an init out-of-band sequence.
// - Sas request starts a sas out-of-band sequence.
// - Wake request starts a wake out-of-band sequence.
// - Mode select 1 makes idle and power inputs asynchronous, 0 synchronous.
// - Power code 00 P0, 01 P0s, 10 P1 with detect, 11 P2.
// - Power transition times are set for into P2, out of P2, others.
// - Each sequence holds burst count plus one bursts.
// - With idle zero enabled, serializer data is zero during electrical idle outside bursts.
// - Detect end shows result and pulses phy status for one cycle.
package txoob_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int DETECT_TIME_NS = 1000;
  localparam int BURST_TIME_NS = 107;
  localparam int INIT_GAP_NS = 320;
  localparam int WAKE_GAP_NS = 107;
  localparam int SAS_GAP_NS = 960;
  localparam logic [7:0] DETECT_CYC = 8'((DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] BURST_CYC = 8'((BURST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] INIT_GAP_CYC = 8'((INIT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WAKE_GAP_CYC = 8'((WAKE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SAS_GAP_CYC = 8'((SAS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMES = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam int CTRL_IDLE_ZERO_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h15;
  localparam logic [23:0] TIMES_RST = 24'h101010;
  localparam int INT_DET_BIT = 0;
  localparam int INT_COM_BIT = 1;
  localparam int INT_PWR_BIT = 2;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PWR_P0 = 2'h0;
  localparam logic [1:0] PWR_P0S = 2'h1;
  localparam logic [1:0] PWR_P1 = 2'h2;
  localparam logic [1:0] PWR_P2 = 2'h3;
  localparam logic [2:0] RXST_PRESENT = 3'h3;
  localparam logic [2:0] RXST_ABSENT = 3'h0;

  typedef enum logic [1:0] {DET_IDLE, DET_DRIVE, DET_HOLD} txoob_det_type;
  typedef enum logic [1:0] {COM_IDLE, COM_BURST, COM_GAP} txoob_com_type;

endpackage

// file: txoob_sync3.sv
// Purpose: Three-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to CLK
// Notes: Output moves only once stages two and three agree
module txoob_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q, s2_q, s3_q, out_q, out_d;

  // Accept a new word only when it has been stable two stages
  always_comb begin
    out_d = (s2_q == s3_q) ? s3_q : out_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign q = out_q;

endmodule

// file: txoob_lane.sv
// Purpose: Lane transmit out-of-band control, receiver detect, power states
// Assumes: CLK is the transmit user clock; AHB-Lite slave, zero wait states
// Notes: Requests arriving while a sequence runs are dropped silently
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
module txoob_lane #(
  parameter int DATA_W = 32
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic RX_DETECT_REQUEST,
  input wire logic INIT_SEQUENCE_REQUEST,
  input wire logic SAS_SEQUENCE_REQUEST,
  input wire logic WAKE_SEQUENCE_REQUEST,
  input wire logic POWERDOWN_SYNC_SELECT,
  input wire logic [1:0] TX_POWER_STATE,
  input wire logic [1:0] RX_POWER_STATE,
  input wire logic TX_ELECTRICAL_IDLE,
  input wire logic FAR_END_SENSE,
  input wire logic [DATA_W-1:0] TX_DATA,
  output logic COM_SEQUENCE_DONE,
  output logic PHY_STATUS,
  output logic [2:0] RX_STATUS,
  output logic [DATA_W-1:0] SERIAL_DATA,
  output logic OOB_BURST,
  output logic LINE_IDLE,
  output logic [1:0] LANE_POWER_STATE,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  logic [6:0] raw_async, syn_async;
  logic async_mode, far_s, eff_eidle;
  logic [1:0] eff_tx_power_state, eff_rx_power_state;

  assign raw_async = {POWERDOWN_SYNC_SELECT, FAR_END_SENSE, TX_ELECTRICAL_IDLE, RX_POWER_STATE, TX_POWER_STATE};

  txoob_sync3 #(.W(7)) u_sync (
    .clk(CLK),
    .rst(RST),
    .d(raw_async),
    .q(syn_async)
  );

  // mode select path
  // Asynchronous mode pays four cycles of latency for metastability safety
  assign async_mode = syn_async[6];
  assign far_s = syn_async[5];
  assign eff_eidle = async_mode ? syn_async[4] : TX_ELECTRICAL_IDLE;
  assign eff_rx_power_state = async_mode ? syn_async[3:2] : RX_POWER_STATE;
  assign eff_tx_power_state = async_mode ? syn_async[1:0] : TX_POWER_STATE;

  // ----------------------------------------------------------------
  // Power state tracking
  // ----------------------------------------------------------------
  logic [1:0] pwr_q, pwr_d, ptgt_q, ptgt_d;
  logic [7:0] ptimer_q, ptimer_d;
  logic pbusy_q, pbusy_d, pwr_done;
  logic [4:0] ctrl_q, ctrl_d;
  logic [23:0] times_q, times_d;
  txoob_pkg::txoob_det_type det_q, det_d;
  logic det_start;

  // Pick the programmed transition time, never below one cycle
  function automatic logic [7:0] trans_time(input logic [1:0] from, input logic [1:0] to,
                                            input logic [23:0] t);
    logic [7:0] v;
    v = t[23:16];
    if (to == txoob_pkg::PWR_P2) begin
      v = t[7:0];
    end else if (from == txoob_pkg::PWR_P2) begin
      v = t[15:8];
    end
    if (v == 8'h00) begin
      v = 8'h01;
    end
    return v;
  endfunction

  // transition timing
  // A change is held off while a detect runs so the lane stays in P1
  always_comb begin
    pwr_d = pwr_q;
    ptgt_d = ptgt_q;
    ptimer_d = ptimer_q;
    pbusy_d = pbusy_q;
    pwr_done = 1'b0;
    if (pbusy_q) begin
      if (ptimer_q == 8'h01) begin
        pwr_d = ptgt_q;
        pbusy_d = 1'b0;
        pwr_done = 1'b1;
      end else begin
        ptimer_d = ptimer_q - 8'h01;
      end
    end else if (eff_tx_power_state != pwr_q && det_q == txoob_pkg::DET_IDLE) begin
      pbusy_d = 1'b1;
      ptgt_d = eff_tx_power_state;
      ptimer_d = trans_time(pwr_q, eff_tx_power_state, times_q);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pwr_q <= txoob_pkg::PWR_P0;
      ptgt_q <= txoob_pkg::PWR_P0;
      ptimer_q <= 8'h00;
      pbusy_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      ptgt_q <= ptgt_d;
      ptimer_q <= ptimer_d;
      pbusy_q <= pbusy_d;
    end
  end

  // ----------------------------------------------------------------
  // Receiver detect
  // ----------------------------------------------------------------
  logic [7:0] dtimer_q, dtimer_d;
  logic [2:0] rxst_q, rxst_d;
  logic phy_q, phy_d, det_done;

  // start only in settled P1 with the request held
  assign det_start = RX_DETECT_REQUEST && !pbusy_q && pwr_q == txoob_pkg::PWR_P1 &&
                     eff_tx_power_state == txoob_pkg::PWR_P1 && eff_rx_power_state == txoob_pkg::PWR_P1;

  // all on the transmit user clock
  always_comb begin
    det_d = det_q;
    dtimer_d = dtimer_q;
    rxst_d = rxst_q;
    det_done = 1'b0;
    case (det_q)
      txoob_pkg::DET_IDLE: begin
        if (det_start) begin
          det_d = txoob_pkg::DET_DRIVE;
          dtimer_d = txoob_pkg::DETECT_CYC;
        end
      end
      txoob_pkg::DET_DRIVE: begin
        if (dtimer_q == 8'h01) begin
          det_d = txoob_pkg::DET_HOLD;
          det_done = 1'b1;
          rxst_d = far_s ? txoob_pkg::RXST_PRESENT : txoob_pkg::RXST_ABSENT;
        end else begin
          dtimer_d = dtimer_q - 8'h01;
        end
      end
      default: begin
        if (!RX_DETECT_REQUEST) begin
          det_d = txoob_pkg::DET_IDLE;
        end
      end
    endcase
    phy_d = det_done || pwr_done;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      det_q <= txoob_pkg::DET_IDLE;
      dtimer_q <= 8'h00;
      rxst_q <= txoob_pkg::RXST_ABSENT;
      phy_q <= 1'b0;
    end else begin
      det_q <= det_d;
      dtimer_q <= dtimer_d;
      rxst_q <= rxst_d;
      phy_q <= phy_d;
    end
  end

  // ----------------------------------------------------------------
  // COM sequence generator and data path
  // ----------------------------------------------------------------
  txoob_pkg::txoob_com_type com_q, com_d;
  logic [7:0] ctimer_q, ctimer_d, gap_q, gap_d;
  logic [3:0] bcnt_q, bcnt_d, bn_q, bn_d;
  logic [2:0] reqs_q, rise;
  logic done_q, done_d, burst_q, burst_d, lidle_q, lidle_d;
  logic [DATA_W-1:0] sdata_q, sdata_d;

  assign rise = {INIT_SEQUENCE_REQUEST, SAS_SEQUENCE_REQUEST, WAKE_SEQUENCE_REQUEST} & ~reqs_q;

  // start; init beats sas beats wake
  always_comb begin
    com_d = com_q;
    ctimer_d = ctimer_q;
    gap_d = gap_q;
    bcnt_d = bcnt_q;
    bn_d = bn_q;
    done_d = 1'b0;
    case (com_q)
      txoob_pkg::COM_IDLE: begin
        if (|rise) begin
          com_d = txoob_pkg::COM_BURST;
          ctimer_d = txoob_pkg::BURST_CYC;
          bcnt_d = 4'h0;
          bn_d = ctrl_q[3:0];
          gap_d = rise[2] ? txoob_pkg::INIT_GAP_CYC :
                  rise[1] ? txoob_pkg::SAS_GAP_CYC : txoob_pkg::WAKE_GAP_CYC;
        end
      end
      txoob_pkg::COM_BURST: begin
        if (ctimer_q != 8'h01) begin
          ctimer_d = ctimer_q - 8'h01;
        end else if (bcnt_q == bn_q) begin
          // single done pulse after the last burst
          com_d = txoob_pkg::COM_IDLE;
          done_d = 1'b1;
        end else begin
          com_d = txoob_pkg::COM_GAP;
          ctimer_d = gap_q;
        end
      end
      default: begin
        if (ctimer_q == 8'h01) begin
          com_d = txoob_pkg::COM_BURST;
          ctimer_d = txoob_pkg::BURST_CYC;
          bcnt_d = bcnt_q + 4'h1;
        end else begin
          ctimer_d = ctimer_q - 8'h01;
        end
      end
    endcase
    burst_d = (com_d == txoob_pkg::COM_BURST);
    lidle_d = eff_eidle && !burst_d;
    sdata_d = (lidle_d && ctrl_q[txoob_pkg::CTRL_IDLE_ZERO_BIT]) ? '0 : TX_DATA;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      com_q <= txoob_pkg::COM_IDLE;
      ctimer_q <= 8'h00;
      gap_q <= 8'h00;
      bcnt_q <= 4'h0;
      bn_q <= 4'h0;
      reqs_q <= 3'h0;
      done_q <= 1'b0;
      burst_q <= 1'b0;
      lidle_q <= 1'b0;
      sdata_q <= '0;
    end else begin
      com_q <= com_d;
      ctimer_q <= ctimer_d;
      gap_q <= gap_d;
      bcnt_q <= bcnt_d;
      bn_q <= bn_d;
      reqs_q <= {INIT_SEQUENCE_REQUEST, SAS_SEQUENCE_REQUEST, WAKE_SEQUENCE_REQUEST};
      done_q <= done_d;
      burst_q <= burst_d;
      lidle_q <= lidle_d;
      sdata_q <= sdata_d;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite registers and interrupt
  // ----------------------------------------------------------------
  logic [7:0] addr_q, addr_d;
  logic wr_q, wr_d, irq_q, irq_d, acc;
  logic [2:0] stat_q, stat_d, mask_q, mask_d, ev, clr;
  logic [31:0] hrdata_q, hrdata_d;
  logic rdy_q, resp_q;

  assign acc = HSEL && HREADY && HTRANS[1];
  assign ev = {pwr_done, done_d, det_done};

  // Read mux sees next values so a read right after a write is current
  always_comb begin
    wr_d = acc && HWRITE;
    addr_d = acc ? HADDR[7:0] : addr_q;
    ctrl_d = ctrl_q;
    times_d = times_q;
    mask_d = mask_q;
    clr = 3'h0;
    if (wr_q) begin
      if (addr_q == txoob_pkg::OFS_CTRL) begin
        ctrl_d = HWDATA[4:0];
      end else if (addr_q == txoob_pkg::OFS_TIMES) begin
        times_d = HWDATA[23:0];
      end else if (addr_q == txoob_pkg::OFS_INT_STAT) begin
        clr = HWDATA[2:0];
      end else if (addr_q == txoob_pkg::OFS_INT_MASK) begin
        mask_d = HWDATA[2:0];
      end
    end
    // New events win over a simultaneous clear
    stat_d = (stat_q & ~clr) | ev;
    irq_d = |(stat_d & mask_d);
    hrdata_d = 32'h0;
    if (acc && !HWRITE) begin
      if (HADDR[7:0] == txoob_pkg::OFS_CTRL) begin
        hrdata_d = {27'h0, ctrl_d};
      end else if (HADDR[7:0] == txoob_pkg::OFS_TIMES) begin
        hrdata_d = {8'h0, times_d};
      end else if (HADDR[7:0] == txoob_pkg::OFS_STATUS) begin
        hrdata_d = {24'h0, async_mode, det_q != txoob_pkg::DET_IDLE,
                    com_q != txoob_pkg::COM_IDLE, rxst_q, pwr_q};
      end else if (HADDR[7:0] == txoob_pkg::OFS_INT_STAT) begin
        hrdata_d = {29'h0, stat_d};
      end else if (HADDR[7:0] == txoob_pkg::OFS_INT_MASK) begin
        hrdata_d = {29'h0, mask_d};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      ctrl_q <= txoob_pkg::CTRL_RST;
      times_q <= txoob_pkg::TIMES_RST;
      mask_q <= 3'h0;
      stat_q <= 3'h0;
      irq_q <= 1'b0;
      hrdata_q <= 32'h0;
      rdy_q <= 1'b1;
      resp_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      wr_q <= wr_d;
      ctrl_q <= ctrl_d;
      times_q <= times_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      irq_q <= irq_d;
      hrdata_q <= hrdata_d;
      rdy_q <= 1'b1;
      resp_q <= 1'b0;
    end
  end

  // Outputs straight from flip-flops
  assign HRDATA = hrdata_q;
  assign HREADYOUT = rdy_q;
  assign HRESP = resp_q;
  assign COM_SEQUENCE_DONE = done_q;
  assign PHY_STATUS = phy_q;
  assign RX_STATUS = rxst_q;
  assign SERIAL_DATA = sdata_q;
  assign OOB_BURST = burst_q;
  assign LINE_IDLE = lidle_q;
  assign LANE_POWER_STATE = pwr_q;
  assign IRQ = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic bprev_q;
  logic [4:0] rcnt_q;

  // Count burst starts within the running sequence
  always_ff @(posedge CLK) begin
    if (RST) begin
      bprev_q <= 1'b0;
      rcnt_q <= 5'h00;
    end else begin
      bprev_q <= burst_q;
      if (com_q == txoob_pkg::COM_IDLE && !burst_q) begin
        rcnt_q <= 5'h00;
      end else if (burst_q && !bprev_q) begin
        rcnt_q <= rcnt_q + 5'h01;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  AST_DET_RESULT: assert property ((det_q == txoob_pkg::DET_DRIVE && dtimer_q == 8'h01) |=>
    PHY_STATUS && RX_STATUS == ($past(far_s) ? 3'h3 : 3'h0)) else $error("detect result wrong");
  AST_PHY_PULSE: assert property (PHY_STATUS |=> !PHY_STATUS) else $error("phy status too long");
  AST_DONE_PULSE: assert property (COM_SEQUENCE_DONE |=> !COM_SEQUENCE_DONE)
    else $error("com done too long");
  AST_DONE_AFTER_BURST: assert property (COM_SEQUENCE_DONE |-> $past(OOB_BURST) && !OOB_BURST)
    else $error("com done not at last burst end");
  AST_INIT_START: assert property ((com_q == txoob_pkg::COM_IDLE && rise[2]) |=>
    OOB_BURST && gap_q == txoob_pkg::INIT_GAP_CYC) else $error("init sequence not started");
  AST_SAS_START: assert property ((com_q == txoob_pkg::COM_IDLE && rise == 3'h2) |=>
    OOB_BURST && gap_q == txoob_pkg::SAS_GAP_CYC) else $error("sas sequence not started");
  AST_WAKE_START: assert property ((com_q == txoob_pkg::COM_IDLE && rise == 3'h1) |=>
    OOB_BURST && gap_q == txoob_pkg::WAKE_GAP_CYC) else $error("wake sequence not started");
  AST_BURST_COUNT: assert property (COM_SEQUENCE_DONE |-> rcnt_q == {1'b0, bn_q} + 5'h01)
    else $error("wrong burst count");
  AST_IDLE_ZERO: assert property ((LINE_IDLE && $past(ctrl_q[4])) |-> SERIAL_DATA == '0)
    else $error("data not zero in idle");
  AST_SYNC_MODE: assert property ((!async_mode && !pbusy_q && det_q == txoob_pkg::DET_IDLE &&
    TX_POWER_STATE != pwr_q) |=> pbusy_q) else $error("sync mode power change late");
  AST_DET_IN_P1: assert property ($rose(det_q == txoob_pkg::DET_DRIVE) |->
    LANE_POWER_STATE == 2'h2 && $past(eff_rx_power_state) == 2'h2) else $error("detect outside P1");
  AST_P2_TIME: assert property ((!pbusy_q && pbusy_d && eff_tx_power_state == 2'h3 && pwr_q != 2'h3) |=>
    ptimer_q == ((times_q[7:0] == 8'h00) ? 8'h01 : $past(times_q[7:0]))) else $error("P2 entry time wrong");

  COV_DETECT: cover property (det_q == txoob_pkg::DET_DRIVE ##1 PHY_STATUS && RX_STATUS == 3'h3);
  COV_COM_DONE: cover property (COM_SEQUENCE_DONE);
  COV_IRQ: cover property (IRQ ##1 !IRQ);

endmodule

// file: txoob_far_rx.sv
// Purpose: Far-end receiver model for the lane out-of-band block
// Assumes: Shares the lane clock; presence is set by the bench
// Notes: Counts bursts and keeps the length of the latest burst
module txoob_far_rx (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic burst,
  input wire logic present,
  output logic sense,
  output int bursts,
  output int last_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_q;
  int len_q;

  // --------------------------------------------------------------
  // Line model
  // --------------------------------------------------------------
  // A terminated far receiver slows the edge, seen as a steady level
  assign sense = present;

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      prev_q <= 1'b0;
      len_q <= 0;
      bursts <= 0;
      last_len <= 0;
    end else begin
      prev_q <= burst;
      if (burst && !prev_q) begin
        bursts <= bursts + 1;
        len_q <= 1;
      end else if (burst) begin
        len_q <= len_q + 1;
      end
      // Length is kept only once the burst has closed
      if (!burst && prev_q) begin
        last_len <= len_q;
      end
    end
  end
endmodule

// file: tb.sv
// Purpose: Self-checking bench for the lane out-of-band block
// Assumes: Zero-wait bus slave; all requests on the lane clock
// Notes: Sequences run one at a time, each waiting for its done pulse
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, com_done, phy_status, oob_burst, line_idle, irq, sense;
  logic det_req = 1'b0, init_req = 1'b0, sas_req = 1'b0, wake_req = 1'b0;
  logic sync_sel = 1'b0, eidle = 1'b0, present = 1'b0, far_clr = 1'b0;
  logic [1:0] pwr = 2'h0;
  logic [1:0] lane_pwr;
  logic [2:0] rx_status;
  logic [31:0] tx_data = 32'h0;
  logic [31:0] ser_data;
  logic [1:0] pseq [3] = '{2'h1, 2'h3, 2'h2};
  int tseq [3] = '{3, 8, 13};
  int nb [3] = '{0, 15, 2};
  int bursts, last_len, n;
  int n_mismatch = 0;
  int tests_run = 0;

  // Half period of the 20 MHz lane clock
  always #25 clk = ~clk;

  txoob_lane i_txoob_lane (.CLK(clk), .RST(rst), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .RX_DETECT_REQUEST(det_req), .INIT_SEQUENCE_REQUEST(init_req), .SAS_SEQUENCE_REQUEST(sas_req),
    .WAKE_SEQUENCE_REQUEST(wake_req), .POWERDOWN_SYNC_SELECT(sync_sel), .TX_POWER_STATE(pwr),
    .RX_POWER_STATE(pwr), .TX_ELECTRICAL_IDLE(eidle), .FAR_END_SENSE(sense), .TX_DATA(tx_data),
    .COM_SEQUENCE_DONE(com_done), .PHY_STATUS(phy_status), .RX_STATUS(rx_status), .SERIAL_DATA(ser_data),
    .OOB_BURST(oob_burst), .LINE_IDLE(line_idle), .LANE_POWER_STATE(lane_pwr), .IRQ(irq));

  txoob_far_rx i_txoob_far_rx (.clk(clk), .rst(rst), .clr(far_clr), .burst(oob_burst), .present(present),
    .sense(sense), .bursts(bursts), .last_len(last_len));

  // --------------------------------------------------------------
  // Compare, bus and wait tasks
  // --------------------------------------------------------------
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      n_mismatch++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Address phase held until ready, then data phase held until ready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
    chk_val("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk_val(what, exp, r);
  endtask

  // Bounded wait for a pulse: 0 selects phy status, 1 com done
  task automatic wait_hi(input int which, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while ((which == 0 ? phy_status : com_done) !== 1'b1 && cnt < 2000);
    if (cnt >= 2000) chk_cnt("pulse wait", 0, cnt);
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog sized well above the roughly 600 cycles of the tests
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk("ctrl", txoob_pkg::OFS_CTRL, {27'h0, txoob_pkg::CTRL_RST});
    rd_chk("times", txoob_pkg::OFS_TIMES, {8'h0, txoob_pkg::TIMES_RST});
    rd_chk("int_mask", txoob_pkg::OFS_INT_MASK, 32'h0);
    // Read-only status and an unmapped word both ignore writes
    wr(txoob_pkg::OFS_STATUS, 32'hFFFFFFFF);
    rd_chk("status", txoob_pkg::OFS_STATUS, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'h40, 32'h0);
    // Distinct times for others, into and out of the lowest state
    wr(txoob_pkg::OFS_TIMES, 32'h030D08);
    rd_chk("times", txoob_pkg::OFS_TIMES, 32'h030D08);
    for (int k = 0; k < 3; k++) begin
      pwr <= pseq[k];
      wait_hi(0, n);
      chk_val("lane power", {30'h0, pseq[k]}, {30'h0, lane_pwr});
      chk_cnt("power time", 1, int'(n >= tseq[k] + 1 && n <= tseq[k] + 3));
      @(posedge clk);
    end
    for (int k = 0; k < 2; k++) begin
      present <= (k == 0);
      repeat (6) @(posedge clk);
      det_req <= 1'b1;
      wait_hi(0, n);
      chk_val("rx status", {29'h0, (k == 0) ? txoob_pkg::RXST_PRESENT : txoob_pkg::RXST_ABSENT}, {29'h0, rx_status});
      chk_cnt("detect time", 1, int'(n >= 21 && n <= 23));
      @(posedge clk);
      chk_val("phy status width", 32'h0, {31'h0, phy_status});
      det_req <= 1'b0;
    end
    for (int k = 0; k < 3; k++) begin
      wr(txoob_pkg::OFS_CTRL, 32'h10 | nb[k]);
      @(posedge clk);
      far_clr <= 1'b1;
      @(posedge clk);
      far_clr <= 1'b0;
      case (k)
        0: init_req <= 1'b1;
        1: sas_req <= 1'b1;
        default: wake_req <= 1'b1;
      endcase
      wait_hi(1, n);
      @(posedge clk);
      chk_val("done width", 32'h0, {31'h0, com_done});
      init_req <= 1'b0;
      sas_req <= 1'b0;
      wake_req <= 1'b0;
      chk_cnt("bursts", nb[k] + 1, bursts);
      chk_cnt("burst length", int'(txoob_pkg::BURST_CYC), last_len);
    end
    rd_chk("int_stat", txoob_pkg::OFS_INT_STAT, 32'h7);
    chk_val("irq masked", 32'h0, {31'h0, irq});
    wr(txoob_pkg::OFS_INT_MASK, 32'h2);
    repeat (2) @(posedge clk);
    chk_val("irq on", 32'h1, {31'h0, irq});
    wr(txoob_pkg::OFS_INT_STAT, 32'h2);
    repeat (2) @(posedge clk);
    chk_val("irq off", 32'h0, {31'h0, irq});
    rd_chk("int_stat", txoob_pkg::OFS_INT_STAT, 32'h5);
    tx_data <= 32'hA5A55A5A;
    eidle <= 1'b1;
    repeat (3) @(posedge clk);
    chk_val("idle data", 32'h0, ser_data);
    chk_val("line idle", 32'h1, {31'h0, line_idle});
    wr(txoob_pkg::OFS_CTRL, 32'h5);
    repeat (3) @(posedge clk);
    chk_val("idle data off", 32'hA5A55A5A, ser_data);
    sync_sel <= 1'b1;
    repeat (6) @(posedge clk);
    rd_chk("status async", txoob_pkg::OFS_STATUS, 32'h82);
    // Asynchronous mode adds four cycles of synchroniser latency to a power change
    pwr <= txoob_pkg::PWR_P0;
    wait_hi(0, n);
    chk_cnt("async power time", 1, int'(n >= tseq[0] + 4 && n <= tseq[0] + 7));
    chk_val("async lane power", {30'h0, txoob_pkg::PWR_P0}, {30'h0, lane_pwr});
    stop_test();
  end
endmodule
